/* File: shared/flash_prot_params.svh */
// Constants of the flash configuration and protection block.
// Assumes byte-wide registers, one per aligned 32-bit Avalon word.
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH
`define CFG_INDEX 3'h3
`define PROT_INDEX 3'h4
`define STATUS_INDEX 3'h5
`define SEC_INDEX 3'h1
`define CFG_BE_IRQ_BIT 7
`define CFG_CC_IRQ_BIT 6
`define CFG_BACKDOOR_KEY_WRITE_ACCESS_BIT 5
`define CFG_WRITE_MASK 8'hE0
`define PROT_POLARITY_BIT 7
`define PROT_SPARE_BIT 6
`define PROT_HDIS_BIT 5
`define PROT_LDIS_BIT 2
`define KEY_ENABLED 2'h2
`define PROT_ADDR 16'hFF0D
`define HIGH_END 16'hFFFF
`define LOW_BASE 16'h4000
`define HIGH_SIZE_BASE 17'h00800
`define LOW_SIZE_BASE 17'h00400
`define CFG_RESET 8'h00
`define PROT_RESET 8'hFF
`endif

/* File: shared/flash_prot_pkg.sv */
// Types of the flash configuration and protection block.
// Assumes nothing of its surroundings.
package flash_prot_pkg;
	typedef enum logic [2:0] {
		ld_idle = 3'b001,
		ld_fetch = 3'b010,
		ld_done = 3'b100
	} load_state_e;
	typedef struct packed {
		logic polarity;
		logic spare;
		logic high_dis;
		logic [1:0] high_size;
		logic low_dis;
		logic [1:0] low_size;
	} prot_s;
endpackage : flash_prot_pkg

/* File: shared/prot_check_if.sv */
// Carries the protection setting and a request to the range checker.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/1ps
interface prot_check_if;
	flash_prot_pkg::prot_s prot;
	logic [15:0] addr;
	logic mass;
	logic refused;
	modport owner (output prot, output addr, output mass, input refused);
	modport checker_side (input prot, input addr, input mass, output refused);
endinterface : prot_check_if

/* File: rtl/prot_range_check.sv */
// Decides whether a program or erase request falls on a protected address.
// Assumes the protection setting is stable while the request is presented.
`timescale 1ns/1ps
`include "flash_prot_params.svh"
module prot_range_check (
	prot_check_if.checker_side chk
);
	logic [16:0] high_len;
	logic [16:0] low_len;
	logic in_high;
	logic in_low;
	logic prot_hit;

	// Range lengths double for each step of the size field
	assign high_len = `HIGH_SIZE_BASE << chk.prot.high_size;
	assign low_len = `LOW_SIZE_BASE << chk.prot.low_size;
	assign in_high = ({1'b0, chk.addr} >= (17'h10000 - high_len)) && !chk.prot.high_dis;
	assign in_low = ({1'b0, chk.addr} >= {1'b0, `LOW_BASE})
		&& ({1'b0, chk.addr} < ({1'b0, `LOW_BASE} + low_len)) && !chk.prot.low_dis;

	// Polarity swaps the meaning of the enabled ranges
	assign prot_hit = chk.prot.polarity ? (in_high || in_low) : !(in_high || in_low);
	// Mass erase needs polarity and both disable bits open
	assign chk.refused = chk.mass ?
		!(chk.prot.polarity && chk.prot.high_dis && chk.prot.low_dis) : prot_hit;
endmodule : prot_range_check

/* File: rtl/prot_scenario.sv */
// Computes the protection scenario of a setting and whether a move is allowed.
// Assumes both settings are valid register images.
`timescale 1ns/1ps
module prot_scenario (
	input flash_prot_pkg::prot_s from_val,
	input flash_prot_pkg::prot_s to_val,
	output logic allowed
);
	// Scenario numbering: open polarity gives 0..3, closed gives 4..7
	function automatic logic [2:0] scen(input flash_prot_pkg::prot_s p);
		logic [2:0] s;
		s = 3'h0;
		// Open: bit 1 marks an enabled high range, bit 0 an enabled low range
		// Closed: bit 1 marks an unprotected low range, bit 0 an unprotected high range
		if (p.polarity)
			s = {1'b0, !p.high_dis, !p.low_dis};
		else
			s = {1'b1, !p.low_dis, !p.high_dis};
		return s;
	endfunction : scen

	logic [2:0] f;
	logic [2:0] t;
	logic [7:0] row;

	assign f = scen(from_val);
	assign t = scen(to_val);

	// Allowed targets per source scenario; only added protection within one polarity, but closed rows also admit open targets
	always_comb
	begin
		case (f)
			3'h0: row = 8'h0F;
			3'h1: row = 8'h0A;
			3'h2: row = 8'h0C;
			3'h3: row = 8'h08;
			3'h4: row = 8'h18;
			3'h5: row = 8'h3C;
			3'h6: row = 8'h5A;
			3'h7: row = 8'hFF;
			default: row = 8'h00;
		endcase
	end
	assign allowed = row[t];
endmodule : prot_scenario

/* File: rtl/flash_config_and_protection.sv */
// Configuration and protection registers of the on-chip flash, on Avalon-MM.
// Assumes the command sequencer supplies status flags and requests.
//
// Behaviour
// - Config keeps only two interrupt enables and key access; others read zero.
// - Key access bit is written only while backdoor key is enabled.
// - Backdoor key counts as enabled only for encoding 10.
// - Buffer-empty interrupt requested when its enable and flag are set.
// - Command-complete interrupt requested when its enable and flag are set.
// - Key access steers array writes to key words and invalidates array reads.
// - Protection register is readable in every operating mode.
// - Polarity bit can only go from one to zero; the scenario table refuses that move too, so writes never change it.
// - Low size field writable only while low disable bit is one.
// - High size field writable only while high disable bit is one.
// - Protection register loads from flash byte 0xFF0D during reset.
// - Program or erase on protected range refused, violation flag set.
// - Mass erase only when polarity and both disables are one.
// - Polarity chooses protected ranges or unprotected ranges.
// - Each disable bit turns its sized range on at zero.
// - High size selects 2, 4, 8 or 16 Kbytes ending at 0xFFFF.
// - Low size selects 1, 2, 4 or 8 Kbytes from 0x4000.
// - Protection writes only add protection; illegal moves ignored entirely.
`timescale 1ns/1ps
`include "flash_prot_params.svh"
module flash_config_and_protection (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] security_register,
	output logic [15:0] nvm_addr,
	output logic nvm_read,
	input wire logic [7:0] nvm_rdata,
	input wire logic nvm_rvalid,
	output logic load_done,
	input wire logic buffer_empty_flag,
	input wire logic cmd_complete_flag,
	output logic buffer_empty_irq,
	output logic cmd_complete_irq,
	input wire logic array_write,
	input wire logic [15:0] array_addr,
	input wire logic array_mass_erase,
	output logic array_cmd_start,
	output logic array_key_write,
	output logic array_read_invalid,
	input wire logic violation_clear,
	output logic protect_violation_flag
);
	flash_prot_pkg::load_state_e ld_q;
	flash_prot_pkg::prot_s prot_q;
	flash_prot_pkg::prot_s prot_d;
	logic buffer_empty_irq_enable;
	logic cmd_complete_irq_enable;
	logic backdoor_key_write_access;
	logic rd_done_q;
	logic wr_hit;
	logic rd_req;
	logic key_enabled;
	logic move_ok;
	logic refused;
	logic [7:0] cfg_rd;
	logic [7:0] wbyte;
	prot_check_if chk ();

	// Register bytes live in the low lane only
	assign wbyte = avs_writedata[7:0];
	assign wr_hit = avs_write && avs_byteenable[0] && (ld_q == flash_prot_pkg::ld_done);
	assign rd_req = avs_read && !rd_done_q;
	// Reads take one wait cycle so that read data come from a flip-flop
	assign avs_waitrequest = rd_req;

	assign key_enabled = (security_register[7:6] == `KEY_ENABLED);

	// Reset-time fetch of the protection byte from the array
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ld_q <= flash_prot_pkg::ld_idle;
		else
			case (ld_q)
				flash_prot_pkg::ld_idle: ld_q <= flash_prot_pkg::ld_fetch;
				flash_prot_pkg::ld_fetch: if (nvm_rvalid) ld_q <= flash_prot_pkg::ld_done;
				flash_prot_pkg::ld_done: ld_q <= flash_prot_pkg::ld_done;
				default: ld_q <= flash_prot_pkg::ld_idle;
			endcase
	end
	assign nvm_addr = `PROT_ADDR;
	assign nvm_read = (ld_q == flash_prot_pkg::ld_fetch);
	assign load_done = (ld_q == flash_prot_pkg::ld_done);

	// Candidate protection value with per-field write gating
	always_comb
	begin
		prot_d = prot_q;
		prot_d.polarity = prot_q.polarity & wbyte[`PROT_POLARITY_BIT];
		prot_d.spare = prot_q.spare;
		prot_d.high_dis = wbyte[`PROT_HDIS_BIT];
		prot_d.low_dis = wbyte[`PROT_LDIS_BIT];
		if (prot_q.high_dis)
			prot_d.high_size = wbyte[4:3];
		if (prot_q.low_dis)
			prot_d.low_size = wbyte[1:0];
	end

	prot_scenario u_scen (
		.from_val(prot_q),
		.to_val(prot_d),
		.allowed(move_ok)
	);

	// Protection register: loaded at reset, then changed only towards more protection
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prot_q <= `PROT_RESET;
		else if (ld_q == flash_prot_pkg::ld_fetch && nvm_rvalid)
			prot_q <= nvm_rdata;
		else if (wr_hit && avs_address == `PROT_INDEX && move_ok)
			prot_q <= prot_d;
	end

	// Configuration bits; the key bit is gated by the security field
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			buffer_empty_irq_enable <= 1'b0;
			cmd_complete_irq_enable <= 1'b0;
			backdoor_key_write_access <= 1'b0;
		end
		else if (wr_hit && avs_address == `CFG_INDEX)
		begin
			buffer_empty_irq_enable <= wbyte[`CFG_BE_IRQ_BIT];
			cmd_complete_irq_enable <= wbyte[`CFG_CC_IRQ_BIT];
			if (key_enabled)
				backdoor_key_write_access <= wbyte[`CFG_BACKDOOR_KEY_WRITE_ACCESS_BIT];
		end
	end

	// Read data register, loaded during the wait cycle
	assign cfg_rd = {buffer_empty_irq_enable, cmd_complete_irq_enable, backdoor_key_write_access, 5'h00};
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			avs_readdata <= 32'h00000000;
			rd_done_q <= 1'b0;
		end
		else
		begin
			rd_done_q <= rd_req;
			if (rd_req)
				case (avs_address)
					`CFG_INDEX: avs_readdata <= {24'h000000, cfg_rd & `CFG_WRITE_MASK};
					`PROT_INDEX: avs_readdata <= {24'h000000, prot_q};
					`SEC_INDEX: avs_readdata <= {24'h000000, security_register};
					`STATUS_INDEX: avs_readdata <= {24'h000000, buffer_empty_flag, cmd_complete_flag,
						protect_violation_flag, 5'h00};
					default: avs_readdata <= 32'h00000000;
				endcase
		end
	end

	// Interrupt requests follow enable and flag in the same cycle
	assign buffer_empty_irq = buffer_empty_irq_enable & buffer_empty_flag;
	assign cmd_complete_irq = cmd_complete_irq_enable & cmd_complete_flag;

	// Protection check of array requests
	assign chk.prot = prot_q;
	assign chk.addr = array_addr;
	assign chk.mass = array_mass_erase;
	assign refused = chk.refused;
	prot_range_check u_chk (
		.chk(chk)
	);

	// Key mode diverts array writes away from the command sequencer
	assign array_key_write = array_write & backdoor_key_write_access;
	assign array_read_invalid = backdoor_key_write_access;
	assign array_cmd_start = array_write & !backdoor_key_write_access & !refused;

	// Violation flag: a new violation wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			protect_violation_flag <= 1'b0;
		else if (array_write && !backdoor_key_write_access && refused)
			protect_violation_flag <= 1'b1;
		else if (violation_clear || (wr_hit && avs_address == `STATUS_INDEX && wbyte[5]))
			protect_violation_flag <= 1'b0;
	end
endmodule : flash_config_and_protection

/* File: verification/fcp_asserts.sv */
// Checker on the ports of the flash configuration and protection block.
// Assumes one clock domain and a one-cycle read wait.
`timescale 1ns/1ps
module fcp_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic buffer_empty_flag,
	input wire logic buffer_empty_irq,
	input wire logic cmd_complete_flag,
	input wire logic cmd_complete_irq,
	input wire logic array_write,
	input wire logic array_cmd_start,
	input wire logic array_key_write,
	input wire logic array_read_invalid,
	input wire logic load_done,
	input wire logic protect_violation_flag
);
	// One domain, so one clock and one reset serve every property
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_be; buffer_empty_irq |-> buffer_empty_flag; endproperty
	a_be: assert property (p_be) else $error("buffer empty irq without flag");
	property p_cc; cmd_complete_irq |-> cmd_complete_flag; endproperty
	a_cc: assert property (p_cc) else $error("complete irq without flag");
	property p_key; array_key_write |-> array_read_invalid && !array_cmd_start; endproperty
	a_key: assert property (p_key) else $error("key write with command start");
	property p_cmd; array_cmd_start |-> array_write && !array_read_invalid; endproperty
	a_cmd: assert property (p_cmd) else $error("command start in key mode");
	// A refused array write must leave the violation flag standing
	property p_ref; array_write && load_done && !array_cmd_start && !array_key_write
		|=> protect_violation_flag; endproperty
	a_ref: assert property (p_ref) else $error("refusal without violation");
	property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("read wait not one cycle");
	property p_zero; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
	a_zero: assert property (p_zero) else $error("upper read bits set");
	property p_ld; load_done |=> load_done; endproperty
	a_ld: assert property (p_ld) else $error("load done dropped");
endmodule : fcp_asserts
bind flash_config_and_protection fcp_asserts fcp_asserts_inst (.clk, .rst, .avs_read, .avs_waitrequest,
	.avs_readdata, .buffer_empty_flag, .buffer_empty_irq, .cmd_complete_flag, .cmd_complete_irq, .array_write,
	.array_cmd_start, .array_key_write, .array_read_invalid, .load_done, .protect_violation_flag);

/* File: verification/tb.sv */
// Self-checking bench for the flash configuration and protection block.
// Assumes the block's hand-over timing; the bench is bus master and flash.
`timescale 1ns/1ps
module tb;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, nvm_read, nvm_rvalid, load_done, violation_clear;
	logic buffer_empty_flag, cmd_complete_flag, buffer_empty_irq, cmd_complete_irq, array_write;
	logic array_mass_erase, array_cmd_start, array_key_write, array_read_invalid, protect_violation_flag;
	logic [2:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] security_register, nvm_rdata, boot_byte;
	logic [15:0] nvm_addr, array_addr;
	int errors, comparisons;
	flash_config_and_protection flash_config_and_protection_inst (.clk, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .security_register,
		.nvm_addr, .nvm_read, .nvm_rdata, .nvm_rvalid, .load_done, .buffer_empty_flag, .cmd_complete_flag,
		.buffer_empty_irq, .cmd_complete_irq, .array_write, .array_addr, .array_mass_erase, .array_cmd_start,
		.array_key_write, .array_read_invalid, .violation_clear, .protect_violation_flag);
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Flash answers a fetch a cycle later; idle data toggles so stale bytes never pass
	always @(posedge clk)
	begin
		if (rst)
		begin
			nvm_rvalid <= 1'b0;
			nvm_rdata <= 8'h00;
		end
		else
		begin
			nvm_rvalid <= nvm_read && !nvm_rvalid;
			nvm_rdata <= nvm_read ? boot_byte : ~nvm_rdata;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles hold until waitrequest is seen low at a rising edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		chk(avs_readdata, {24'h0, e});
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : rd
	// One array write; the flag is cleared afterwards so each call stands alone
	task automatic arr(input logic [15:0] a, input logic m, input logic st, input logic vi);
		array_addr <= a;
		array_mass_erase <= m;
		array_write <= 1'b1;
		@(negedge clk);
		chk(array_cmd_start, st);
		@(posedge clk);
		array_write <= 1'b0;
		violation_clear <= 1'b1;
		@(negedge clk);
		chk(protect_violation_flag, vi);
		@(posedge clk);
		violation_clear <= 1'b0;
	endtask : arr
	task automatic do_reset(input logic [7:0] b);
		boot_byte <= b;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (30) if (load_done !== 1'b1) @(negedge clk);
		@(posedge clk);
		rd(3'h4, b);
		chk(nvm_addr, 32'h0000FF0D);
	endtask : do_reset
	task automatic t_cfg;
		for (int k = 0; k < 4; k++)
		begin
			security_register <= 8'(k << 6);
			wr(3'h3, 8'h3F);
			rd(3'h3, k == 2 ? 8'h20 : 8'h00);
			chk(array_read_invalid, k == 2);
			security_register <= 8'h80;
			wr(3'h3, 8'h00);
		end
		wr(3'h3, 8'h20);
		arr(16'h6000, 1'b0, 1'b0, 1'b0);
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00);
		rd(3'h3, 8'h20);
		wr(3'h3, 8'h00);
		$display("config test done");
	endtask : t_cfg
	task automatic t_irq;
		wr(3'h3, 8'hC0);
		buffer_empty_flag <= 1'b1;
		cmd_complete_flag <= 1'b1;
		@(negedge clk);
		chk({buffer_empty_irq, cmd_complete_irq}, 2'b11);
		@(posedge clk);
		wr(3'h3, 8'h40);
		chk({buffer_empty_irq, cmd_complete_irq}, 2'b01);
		wr(3'h3, 8'h80);
		chk({buffer_empty_irq, cmd_complete_irq}, 2'b10);
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_prot;
		arr(16'hFF0D, 1'b0, 1'b1, 1'b0);
		arr(16'h4000, 1'b1, 1'b1, 1'b0);
		wr(3'h4, 8'hFB);
		rd(3'h4, 8'hFB);
		wr(3'h4, 8'hF8);
		rd(3'h4, 8'hFB);
		wr(3'h4, 8'h7B);
		rd(3'h4, 8'hFB);
		arr(16'h5FFF, 1'b0, 1'b0, 1'b1);
		arr(16'h6000, 1'b0, 1'b1, 1'b0);
		arr(16'h6000, 1'b1, 1'b0, 1'b1);
		wr(3'h4, 8'hDB);
		wr(3'h4, 8'hC3);
		rd(3'h4, 8'hDB);
		arr(16'hC000, 1'b0, 1'b0, 1'b1);
		// A violation and a clear in one cycle: the violation must stand
		@(posedge clk);
		array_write <= 1'b1;
		violation_clear <= 1'b1;
		@(posedge clk);
		array_write <= 1'b0;
		violation_clear <= 1'b0;
		@(posedge clk);
		rd(3'h5, 8'hE0);
		wr(3'h5, 8'h20);
		chk(protect_violation_flag, 1'b0);
		arr(16'hBFFF, 1'b0, 1'b1, 1'b0);
		do_reset(8'h7B);
		wr(3'h4, 8'hFB);
		rd(3'h4, 8'h7B);
		arr(16'h5FFF, 1'b0, 1'b1, 1'b0);
		arr(16'h6000, 1'b0, 1'b0, 1'b1);
		$display("protection test done");
	endtask : t_prot
	task automatic stop_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// Main sequence; byte enables stay full since every register is one byte
	initial
	begin
		rst = 1'b1;
		{avs_read, avs_write, array_write, array_mass_erase, violation_clear} = 5'h00;
		{buffer_empty_flag, cmd_complete_flag, avs_address, array_addr} = 21'h0;
		{avs_byteenable, avs_writedata, security_register} = 44'hF_0000_0000_80;
		do_reset(8'hFF);
		t_cfg();
		t_irq();
		t_prot();
		stop_test();
	end
	// Tests need under a thousand cycles; this cuts a hang well beyond that
	initial
	begin
		#200000;
		errors++;
		stop_test();
	end
endmodule : tb
